// ### include/usf_defines.svh
// Purpose: register map, field positions, reset values of the serial flag block
// Assumes: 32-bit AXI4-Lite register window, word aligned offsets
// Notes: definitions only
`ifndef USF_DEFINES_SVH
`define USF_DEFINES_SVH

// register byte offsets
`define USF_MODE_OFS 8'h00
`define USF_CTRL_OFS 8'h04
`define USF_STAT_OFS 8'h08
`define USF_RDATA_OFS 8'h0C
`define USF_TDATA_OFS 8'h10
`define USF_BAUD_OFS 8'h14
`define USF_IRQ_STAT_OFS 8'h18
`define USF_IRQ_EN_OFS 8'h1C
`define USF_IRQ_CLR_OFS 8'h20

// serial_mode_reg fields
`define USF_MODE_PAR_EN 0
`define USF_MODE_PAR_ODD 1
// serial_control_reg fields
`define USF_CTRL_TX_EN 0
`define USF_CTRL_RX_EN 1
// status and interrupt layout
`define USF_FLAG_PER 0
`define USF_FLAG_FER 1
`define USF_FLAG_OER 2
`define USF_FLAG_RXF 3
`define USF_FLAG_TXE 4
`define USF_NFLAGS 5

// reset values
`define USF_BAUD_RST 16'h087A
`define USF_FLAGS_RST 5'h10
`define USF_DATA_BITS 8

// bus responses
`define USF_RESP_OKAY 2'h0
`define USF_RESP_DECERR 2'h3

`endif

// ### include/usf_pkg.sv
// Purpose: types shared by the serial flag block
// Assumes: usf_defines.svh included first
// Notes: flag struct order matches the status register bits
`include "usf_defines.svh"
package usf_pkg;
	// status flags, bit 0 at the bottom
	typedef struct packed {
		logic tx_empty_flag;
		logic rx_full_flag;
		logic overrun_err_flag;
		logic framing_err_flag;
		logic parity_err_flag;
	} usf_flags_t;

	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} usf_rx_state_t;
endpackage

// ### rtl/usf_sync.sv
// Purpose: two flop synchroniser for an asynchronous level
// Assumes: input carries no relation to aclk
// Notes: first flop feeds only the second
`timescale 1ns/1ps
module usf_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] sync_ff;

	// metastability settles in meta_ff
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_ff <= RST_VAL;
			sync_ff <= RST_VAL;
		end else begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
		end
	end

	assign sync_out = sync_ff;
endmodule // usf_sync

// ### rtl/usf_top.sv
// Purpose: serial line with framing, overrun, parity, rx full and tx empty flags
// Assumes: aclk 250 MHz, rx line asynchronous, AXI4-Lite register access
// Notes: flags clear by read-as-1 then write-0, or by buffer access
//
// The AXI4-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "usf_defines.svh"
module usf_top import usf_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic rx_line_in,
	output logic tx_line_out,
	output logic irq_out
);
	// bus slave state
	logic aw_have_ff, w_have_ff, bvalid_ff, rvalid_ff;
	logic [7:0] awaddr_ff;
	logic [31:0] wdata_ff, rdata_ff;
	logic [3:0] wstrb_ff;
	logic [1:0] bresp_ff, rresp_ff;
	// registers
	logic [1:0] serial_mode_reg_ff, serial_control_reg_ff;
	logic [15:0] baud_div_ff;
	usf_flags_t flags_ff;
	logic [`USF_NFLAGS-1:0] armed_ff, irq_stat_ff, irq_en_ff, events;
	logic [7:0] rx_data_buffer_ff, tx_data_buffer_ff;
	// receiver
	usf_rx_state_t rx_state_ff;
	logic [15:0] rx_cnt_ff;
	logic [2:0] rx_bit_ff;
	logic [7:0] rx_shift_register_ff;
	logic rx_par_ff, rx_prev_ff, rx_s, rx_tick;
	// transmitter
	logic [10:0] tx_shift_register_ff;
	logic [3:0] tx_bits_ff;
	logic [15:0] tx_cnt_ff;

	logic wr_fire, rd_fire, wr_stat, rd_rdata, wr_tdata;
	logic rx_done, frame_bad, par_bad, rx_overrun, rx_ok, tx_load;
	logic par_en, par_odd, tx_enable_bit, rx_enable_bit;
	logic [`USF_NFLAGS-1:0] clr_req;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// rx pin crosses into aclk; idle line is high
	usf_sync #(.WIDTH(1), .RST_VAL(1'b1)) u_rx_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.async_in(rx_line_in),
		.sync_out(rx_s)
	);

	assign par_en = serial_mode_reg_ff[`USF_MODE_PAR_EN];
	assign par_odd = serial_mode_reg_ff[`USF_MODE_PAR_ODD];
	assign tx_enable_bit = serial_control_reg_ff[`USF_CTRL_TX_EN];
	assign rx_enable_bit = serial_control_reg_ff[`USF_CTRL_RX_EN];

	// write address and data taken in either order, answered when both held
	assign s_axi_awready = !aw_have_ff && !bvalid_ff;
	assign s_axi_wready = !w_have_ff && !bvalid_ff;
	assign s_axi_arready = !rvalid_ff;
	assign wr_fire = aw_have_ff && w_have_ff && !bvalid_ff;
	assign rd_fire = s_axi_arvalid && s_axi_arready;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rresp = rresp_ff;
	assign s_axi_rdata = rdata_ff;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_ff <= 1'b0;
			w_have_ff <= 1'b0;
			awaddr_ff <= 8'h00;
			wdata_ff <= 32'h00000000;
			wstrb_ff <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_ff <= 1'b1;
				awaddr_ff <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_have_ff <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_ff <= 1'b1;
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_have_ff <= 1'b0;
			end
		end
	end

	// write response; unmapped addresses answer decode error
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_ff <= 1'b0;
			bresp_ff <= `USF_RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_ff <= 1'b1;
			if (awaddr_ff <= `USF_IRQ_CLR_OFS && awaddr_ff[1:0] == 2'h0) begin
				bresp_ff <= `USF_RESP_OKAY;
			end else begin
				bresp_ff <= `USF_RESP_DECERR;
			end
		end else if (s_axi_bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	// register writes need byte lane 0; the baud high byte also needs lane 1
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			serial_mode_reg_ff <= 2'h0;
			serial_control_reg_ff <= 2'h0;
			baud_div_ff <= `USF_BAUD_RST;
			irq_en_ff <= 5'h00;
			tx_data_buffer_ff <= 8'h00;
		end else if (wr_fire && wstrb_ff[0]) begin
			if (awaddr_ff == `USF_MODE_OFS) begin
				serial_mode_reg_ff <= wdata_ff[1:0];
			end else if (awaddr_ff == `USF_CTRL_OFS) begin
				serial_control_reg_ff <= wdata_ff[1:0];
			end else if (awaddr_ff == `USF_TDATA_OFS) begin
				tx_data_buffer_ff <= wdata_ff[7:0];
			end else if (awaddr_ff == `USF_BAUD_OFS) begin
				baud_div_ff[7:0] <= wdata_ff[7:0];
				if (wstrb_ff[1]) begin
					baud_div_ff[15:8] <= wdata_ff[15:8];
				end
			end else if (awaddr_ff == `USF_IRQ_EN_OFS) begin
				irq_en_ff <= wdata_ff[`USF_NFLAGS-1:0];
			end
		end
	end

	assign wr_stat = wr_fire && wstrb_ff[0] && awaddr_ff == `USF_STAT_OFS;
	assign wr_tdata = wr_fire && wstrb_ff[0] && awaddr_ff == `USF_TDATA_OFS;
	assign rd_rdata = rd_fire && s_axi_araddr == `USF_RDATA_OFS;
	// a 0 written clears only a bit seen as 1 by the last status read
	assign clr_req = wr_stat ? (~wdata_ff[`USF_NFLAGS-1:0] & armed_ff) : 5'h00;

	// read mux; status read arms the write-0 clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h00000000;
			rresp_ff <= `USF_RESP_OKAY;
			armed_ff <= 5'h00;
		end else begin
			if (rd_fire) begin
				rvalid_ff <= 1'b1;
				rresp_ff <= `USF_RESP_OKAY;
				rdata_ff <= 32'h00000000;
				if (s_axi_araddr == `USF_MODE_OFS) begin
					rdata_ff[1:0] <= serial_mode_reg_ff;
				end else if (s_axi_araddr == `USF_CTRL_OFS) begin
					rdata_ff[1:0] <= serial_control_reg_ff;
				end else if (s_axi_araddr == `USF_STAT_OFS) begin
					rdata_ff[`USF_NFLAGS-1:0] <= flags_ff;
				end else if (s_axi_araddr == `USF_RDATA_OFS) begin
					rdata_ff[7:0] <= rx_data_buffer_ff;
				end else if (s_axi_araddr == `USF_TDATA_OFS) begin
					rdata_ff[7:0] <= tx_data_buffer_ff;
				end else if (s_axi_araddr == `USF_BAUD_OFS) begin
					rdata_ff[15:0] <= baud_div_ff;
				end else if (s_axi_araddr == `USF_IRQ_STAT_OFS) begin
					rdata_ff[`USF_NFLAGS-1:0] <= irq_stat_ff;
				end else if (s_axi_araddr == `USF_IRQ_EN_OFS) begin
					rdata_ff[`USF_NFLAGS-1:0] <= irq_en_ff;
				end else if (s_axi_araddr != `USF_IRQ_CLR_OFS) begin
					rresp_ff <= `USF_RESP_DECERR;
				end
			end else if (s_axi_rready) begin
				rvalid_ff <= 1'b0;
			end
			if (rd_fire && s_axi_araddr == `USF_STAT_OFS) begin
				armed_ff <= flags_ff;
			end else if (wr_stat) begin
				armed_ff <= 5'h00;
			end
		end
	end

	// receiver: half-bit delay to mid start bit, then one bit per divisor
	assign rx_tick = (rx_state_ff != RX_IDLE) && rx_cnt_ff == 16'h0000;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_state_ff <= RX_IDLE;
			rx_cnt_ff <= 16'h0000;
			rx_bit_ff <= 3'h0;
			rx_shift_register_ff <= 8'h00;
			rx_par_ff <= 1'b0;
			rx_prev_ff <= 1'b1;
		end else begin
			rx_prev_ff <= rx_s;
			if (rx_state_ff != RX_IDLE) begin
				rx_cnt_ff <= rx_tick ? baud_div_ff - 16'h0001 : rx_cnt_ff - 16'h0001;
			end
			case (rx_state_ff)
				RX_IDLE: begin
					if (rx_enable_bit && rx_prev_ff && !rx_s) begin
						rx_state_ff <= RX_START;
						rx_cnt_ff <= {1'b0, baud_div_ff[15:1]};
					end
				end
				RX_START: begin
					if (rx_tick) begin
						rx_state_ff <= rx_s ? RX_IDLE : RX_DATA; // glitch rejected
						rx_bit_ff <= 3'h0;
					end
				end
				RX_DATA: begin
					if (rx_tick) begin
						rx_shift_register_ff <= {rx_s, rx_shift_register_ff[7:1]};
						rx_bit_ff <= rx_bit_ff + 3'h1;
						if (rx_bit_ff == 3'h7) begin
							rx_state_ff <= par_en ? RX_PAR : RX_STOP;
						end
					end
				end
				RX_PAR: begin
					if (rx_tick) begin
						rx_par_ff <= rx_s;
						rx_state_ff <= RX_STOP;
					end
				end
				RX_STOP: begin
					if (rx_tick) begin
						rx_state_ff <= RX_IDLE;
					end
				end
				default: rx_state_ff <= RX_IDLE;
			endcase
		end
	end

	// completion checks at the stop bit sample
	assign rx_done = rx_state_ff == RX_STOP && rx_tick;
	assign frame_bad = !rx_s;
	assign par_bad = par_en && ((^{rx_shift_register_ff, rx_par_ff}) != par_odd);
	assign rx_overrun = rx_done && flags_ff.rx_full_flag;
	assign rx_ok = rx_done && !flags_ff.rx_full_flag && !frame_bad && !par_bad;

	// buffer only loads when empty, so an overrun keeps the old character
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_data_buffer_ff <= 8'h00;
		end else if (rx_ok) begin
			rx_data_buffer_ff <= rx_shift_register_ff;
		end
	end

	// transmitter: frame is start, data lsb first, optional parity, stop
	assign tx_load = tx_enable_bit && !flags_ff.tx_empty_flag && tx_bits_ff == 4'h0;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_shift_register_ff <= 11'h7FF;
			tx_bits_ff <= 4'h0;
			tx_cnt_ff <= 16'h0000;
		end else if (tx_load) begin
			tx_shift_register_ff <= {1'b1, par_en ? (^tx_data_buffer_ff) ^ par_odd : 1'b1,
				tx_data_buffer_ff, 1'b0};
			tx_bits_ff <= par_en ? 4'hB : 4'hA;
			tx_cnt_ff <= baud_div_ff - 16'h0001;
		end else if (tx_bits_ff != 4'h0) begin
			if (tx_cnt_ff == 16'h0000) begin
				tx_shift_register_ff <= {1'b1, tx_shift_register_ff[10:1]};
				tx_bits_ff <= tx_bits_ff - 4'h1;
				tx_cnt_ff <= baud_div_ff - 16'h0001;
			end else begin
				tx_cnt_ff <= tx_cnt_ff - 16'h0001;
			end
		end
	end
	assign tx_line_out = tx_shift_register_ff[0];

	// status flags; every hardware set wins over a clear in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flags_ff <= `USF_FLAGS_RST;
		end else begin
			if (rx_done && par_bad) begin
				flags_ff.parity_err_flag <= 1'b1;
			end else if (clr_req[`USF_FLAG_PER]) begin
				flags_ff.parity_err_flag <= 1'b0;
			end
			if (rx_done && frame_bad) begin
				flags_ff.framing_err_flag <= 1'b1;
			end else if (clr_req[`USF_FLAG_FER]) begin
				flags_ff.framing_err_flag <= 1'b0;
			end
			if (rx_overrun) begin
				flags_ff.overrun_err_flag <= 1'b1;
			end else if (clr_req[`USF_FLAG_OER]) begin
				flags_ff.overrun_err_flag <= 1'b0;
			end
			if (rx_ok) begin
				flags_ff.rx_full_flag <= 1'b1;
			end else if (rd_rdata || clr_req[`USF_FLAG_RXF]) begin
				flags_ff.rx_full_flag <= 1'b0;
			end
			if (!tx_enable_bit || tx_load) begin
				flags_ff.tx_empty_flag <= 1'b1;
			end else if (wr_tdata || clr_req[`USF_FLAG_TXE]) begin
				flags_ff.tx_empty_flag <= 1'b0;
			end
		end
	end

	// interrupt: sticky events, set beats write-1 clear
	assign events = {tx_load, rx_ok, rx_overrun, rx_done && frame_bad, rx_done && par_bad};
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat_ff <= 5'h00;
		end else if (wr_fire && wstrb_ff[0] && awaddr_ff == `USF_IRQ_CLR_OFS) begin
			irq_stat_ff <= (irq_stat_ff & ~wdata_ff[`USF_NFLAGS-1:0]) | events;
		end else begin
			irq_stat_ff <= irq_stat_ff | events;
		end
	end
	assign irq_out = |(irq_stat_ff & irq_en_ff);

	chk_fer_set_on_stop: assert property (rx_done && frame_bad |=> flags_ff.framing_err_flag)
		else $error("framing error not set on low stop bit");
	chk_fer_needs_read: assert property (flags_ff.framing_err_flag && !armed_ff[`USF_FLAG_FER]
		|=> flags_ff.framing_err_flag)
		else $error("framing error cleared without prior read");
	chk_oer_set_full: assert property (rx_done && flags_ff.rx_full_flag
		|=> flags_ff.overrun_err_flag)
		else $error("overrun not set");
	chk_oer_clear_write: assert property (flags_ff.overrun_err_flag && wr_stat
		&& !wdata_ff[`USF_FLAG_OER] && armed_ff[`USF_FLAG_OER] && !rx_overrun
		|=> !flags_ff.overrun_err_flag)
		else $error("overrun not cleared by armed write 0");
	chk_rxf_set_clean: assert property (rx_ok |=> flags_ff.rx_full_flag
		&& rx_data_buffer_ff == $past(rx_shift_register_ff))
		else $error("clean reception not stored");
	chk_rxf_read_clear: assert property (rd_rdata && !rx_ok |=> !flags_ff.rx_full_flag)
		else $error("rx full not cleared by buffer read");
	chk_txe_write_clear: assert property (wr_tdata && tx_enable_bit
		&& flags_ff.tx_empty_flag |=> !flags_ff.tx_empty_flag ##1 tx_bits_ff != 4'h0)
		else $error("tx empty not cleared or frame not started");
	chk_txe_load_set: assert property (tx_load |=> flags_ff.tx_empty_flag && !tx_line_out)
		else $error("tx empty not set on shifter load");
	chk_txe_force_off: assert property (!tx_enable_bit |=> flags_ff.tx_empty_flag)
		else $error("tx empty not forced while disabled");
	chk_per_set_bad: assert property (rx_done && par_bad |=> flags_ff.parity_err_flag)
		else $error("parity error not set");
	chk_rdr_kept_ovr: assert property (rx_overrun |=> $stable(rx_data_buffer_ff))
		else $error("buffer overwritten on overrun");
endmodule // usf_top

// ### tb/usf_peer.sv
// Purpose: far-end serial device model for the flag block bench
// Assumes: 8 data bits lsb first, one bit lasts BIT_CYC aclk cycles
// Notes: frames go out on request only; the line idles high between them
`timescale 1ns/1ps
module usf_peer #(
	parameter int BIT_CYC = 8
) (
	input wire logic aclk,
	output logic line_out,
	input wire logic line_in
);
	initial line_out = 1'b1;

	// one frame out; caller picks parity and stop to force errors
	task automatic send(input logic [7:0] d, input logic pe, input logic pb, input logic sb);
		logic q[$];
		q = {1'b0};
		for (int i = 0; i < 8; i++)
			q.push_back(d[i]);
		if (pe)
			q.push_back(pb);
		q.push_back(sb);
		foreach (q[i]) begin
			line_out <= q[i];
			repeat (BIT_CYC) @(posedge aclk);
		end
		line_out <= 1'b1;
		repeat (2 * BIT_CYC) @(posedge aclk);
	endtask

	// one frame in, sampled mid-bit; start wait is bounded
	task automatic recv(output logic [7:0] d, output bit ok);
		int t;
		ok = 1'b0;
		d = 8'h00;
		for (t = 0; t < 4000 && line_in !== 1'b0; t++)
			@(posedge aclk);
		if (line_in !== 1'b0)
			return;
		repeat (BIT_CYC / 2) @(posedge aclk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CYC) @(posedge aclk);
			d[i] = line_in;
		end
		repeat (BIT_CYC) @(posedge aclk);
		ok = (line_in === 1'b1);
	endtask
endmodule // usf_peer

// ### tb/tb.sv
// Purpose: self-checking bench for the serial flag block
// Assumes: bit time cut to BAUD cycles through the divisor register
// Notes: each scenario task drives the block and judges what comes back
`timescale 1ns/1ps
`include "usf_defines.svh"
module tb;
	localparam int BAUD = 8;
	localparam logic [31:0] f_par = 32'h1 << `USF_FLAG_PER;
	localparam logic [31:0] f_frm = 32'h1 << `USF_FLAG_FER;
	localparam logic [31:0] f_ovr = 32'h1 << `USF_FLAG_OER;
	localparam logic [31:0] f_rxf = 32'h1 << `USF_FLAG_RXF;
	localparam logic [31:0] f_txe = 32'h1 << `USF_FLAG_TXE;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hF;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, tx_line, rx_line, irq;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	int failures = 0;
	int num_checks = 0;

	usf_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .rx_line_in(rx_line), .tx_line_out(tx_line), .irq_out(irq));
	usf_peer #(.BIT_CYC(BAUD)) peer (.aclk(aclk), .line_out(rx_line), .line_in(tx_line));

	// 250 MHz clock
	initial begin
		forever #2 aclk = ~aclk;
	end

	task automatic report_and_stop();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic tmo();
		failures++;
		report_and_stop();
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] e, input string m);
		num_checks++;
		if (got !== e) begin
			failures++;
			$display("wrong value at %0t: %s got %h exp %h", $time, m, got, e);
		end
	endtask

	// handshakes judged at the falling edge, released after the rising one
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw, w, b;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		b = 1'b0;
		for (int t = 0; t < 50 && !b; t++) begin
			@(negedge aclk);
			aw = awvalid && awready;
			w = wvalid && wready;
			b = bvalid;
			r = bresp;
			@(posedge aclk);
			if (aw)
				awvalid <= 1'b0;
			if (w)
				wvalid <= 1'b0;
			if (b)
				bready <= 1'b0;
		end
		// idle edge: a back-to-back call must not re-raise bready in this step
		@(posedge aclk);
		if (b !== 1'b1)
			tmo();
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ar, rv;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		rv = 1'b0;
		for (int t = 0; t < 50 && !rv; t++) begin
			@(negedge aclk);
			ar = arvalid && arready;
			rv = rvalid;
			d = rdata;
			r = rresp;
			@(posedge aclk);
			if (ar)
				arvalid <= 1'b0;
			if (rv)
				rready <= 1'b0;
		end
		// idle edge: a back-to-back call must not re-raise rready in this step
		@(posedge aclk);
		if (rv !== 1'b1)
			tmo();
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		axi_wr(a, d, r);
		chk({30'h0, r}, {30'h0, `USF_RESP_OKAY}, "bresp");
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string m);
		logic [31:0] d;
		logic [1:0] r;
		axi_rd(a, d, r);
		chk({30'h0, r}, {30'h0, `USF_RESP_OKAY}, m);
		chk(d, e, m);
	endtask

	// unarmed write of 0 must not clear; armed one must
	task automatic clr_seq(input logic [31:0] st);
		rd_chk(`USF_STAT_OFS, st, "armed");
		wr(`USF_STAT_OFS, 32'h1F);
		wr(`USF_STAT_OFS, f_txe);
		rd_chk(`USF_STAT_OFS, st, "kept");
		wr(`USF_STAT_OFS, f_txe);
		rd_chk(`USF_STAT_OFS, f_txe, "cleared");
	endtask

	task automatic t_reset();
		logic [31:0] d;
		logic [1:0] r;
		rd_chk(`USF_STAT_OFS, f_txe, "stat rst");
		rd_chk(`USF_BAUD_OFS, {16'h0, `USF_BAUD_RST}, "baud rst");
		axi_rd(8'h24, d, r);
		chk({30'h0, r}, {30'h0, `USF_RESP_DECERR}, "unmapped rd");
		axi_wr(8'h24, 32'h0, r);
		chk({30'h0, r}, {30'h0, `USF_RESP_DECERR}, "unmapped wr");
		wr(`USF_BAUD_OFS, BAUD);
		wr(`USF_CTRL_OFS, 32'h3);
	endtask

	task automatic t_rx();
		logic [31:0] d;
		logic [1:0] r;
		peer.send(8'hA5, 1'b0, 1'b0, 1'b1);
		rd_chk(`USF_STAT_OFS, f_txe | f_rxf, "rx full");
		axi_rd(`USF_IRQ_STAT_OFS, d, r);
		chk(d & 32'h8, 32'h8, "irq stat");
		chk({31'h0, irq}, 32'h0, "irq masked");
		wr(`USF_IRQ_EN_OFS, 32'h8);
		chk({31'h0, irq}, 32'h1, "irq up");
		wr(`USF_IRQ_CLR_OFS, 32'h8);
		chk({31'h0, irq}, 32'h0, "irq cleared");
		peer.send(8'h3C, 1'b0, 1'b0, 1'b1);
		rd_chk(`USF_STAT_OFS, f_txe | f_rxf | f_ovr, "overrun");
		rd_chk(`USF_RDATA_OFS, 32'hA5, "first kept");
		rd_chk(`USF_STAT_OFS, f_txe | f_ovr, "read clears");
		clr_seq(f_txe | f_ovr);
	endtask

	task automatic t_frame();
		peer.send(8'h55, 1'b0, 1'b0, 1'b0);
		clr_seq(f_txe | f_frm);
		peer.send(8'h81, 1'b0, 1'b0, 1'b1);
		clr_seq(f_txe | f_rxf);
	endtask

	// even then odd parity, one bad frame and one good each
	task automatic t_parity();
		for (int m = 1; m <= 3; m += 2) begin
			wr(`USF_MODE_OFS, m);
			peer.send(8'h03, 1'b1, m == 1, 1'b1);
			clr_seq(f_txe | f_par);
			peer.send(8'h03, 1'b1, m != 1, 1'b1);
			rd_chk(`USF_RDATA_OFS, 32'h03, "parity good");
			rd_chk(`USF_STAT_OFS, f_txe, "rx drained");
		end
		wr(`USF_MODE_OFS, 32'h0);
	endtask

	task automatic t_tx();
		logic [7:0] d1, d2;
		bit ok1, ok2;
		fork
			begin
				peer.recv(d1, ok1);
				peer.recv(d2, ok2);
			end
			begin
				wr(`USF_TDATA_OFS, 32'h96);
				wr(`USF_TDATA_OFS, 32'h5A);
				rd_chk(`USF_STAT_OFS, 32'h0, "tx pending");
			end
		join
		chk({24'h0, d1}, 32'h96, "tx first");
		chk({24'h0, d2}, 32'h5A, "tx second");
		chk({30'h0, ok1, ok2}, 32'h3, "tx stop");
		rd_chk(`USF_STAT_OFS, f_txe, "tx moved");
		wr(`USF_TDATA_OFS, 32'h33);
		wr(`USF_TDATA_OFS, 32'h44);
		wr(`USF_CTRL_OFS, 32'h2);
		rd_chk(`USF_STAT_OFS, f_txe, "tx off");
	endtask

	// reset, then the scenarios in turn
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset();
		t_rx();
		t_frame();
		t_parity();
		t_tx();
		report_and_stop();
	end

	// cut a hang short
	initial begin
		repeat (100000) @(posedge aclk);
		tmo();
	end
endmodule // tb
